// ==== hdl/alc_cfg.svh ====
// Constants for the battery aware level limiter: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the limiter modules.
`ifndef ALC_CFG_SVH
`define ALC_CFG_SVH

// ******************************
// Register offsets
// ******************************
`define ALC_OFS_GAIN_LIMITS 8'h2c
`define ALC_OFS_STEP_TIMING 8'h2d
`define ALC_OFS_MODE_BATTERY 8'h2e
`define ALC_OFS_EXTRA 8'h2f
`define ALC_OFS_STATUS 8'h30

// ******************************
// Reset values
// ******************************
`define ALC_RST_GAIN_LIMITS 16'h0000
`define ALC_RST_STEP_TIMING 16'h0000
`define ALC_RST_MODE_BATTERY 16'h0000
`define ALC_RST_EXTRA 16'h0020

// ******************************
// Field positions
// ******************************
`define ZERO_CROSS_UPDATE_BIT 14
`define ALC_PKSEL_BIT 11
`define ALC_MAXG_HI 7
`define ALC_MAXG_LO 5
`define ALC_MING_HI 3
`define ALC_MING_LO 1
`define ALC_DCY_HI 15
`define ALC_DCY_LO 12
`define ALC_ATK_HI 11
`define ALC_ATK_LO 8
`define ALC_HLD_HI 7
`define ALC_HLD_LO 4
`define ALC_LVL_HI 3
`define ALC_LVL_LO 1
`define LEVEL_CONTROL_ENABLE_BIT 15
`define ALC_MODE_HI 14
`define ALC_MODE_LO 12
`define ALC_RATIO_HI 11
`define ALC_RATIO_LO 10
`define ALC_THR_HI 9
`define ALC_THR_LO 5

// ******************************
// Modes and gain scale
// ******************************
`define ALC_MODE_NORMAL 3'h2
`define ALC_MODE_LOWBAT 3'h3
`define ALC_MODE_RATIO 3'h4
`define ALC_GAIN_FIELD_TOP 3'h7

// ******************************
// Timing, base interval per field code zero
// ******************************
`define ALC_CLK_PERIOD_NS 100
`define ALC_ATK_BASE_NS 2000
`define ALC_DCY_BASE_NS 500000
`define ALC_HLD_BASE_NS 1000000

`endif

// ==== hdl/alc_pkg.sv ====
// Types shared by the level limiter modules.
// Assumes alc_cfg.svh is on the include path.
package alc_pkg;
  `include "alc_cfg.svh"

  typedef enum logic [2:0] {ST_IDLE, ST_MONITOR, ST_ATTACK, ST_HOLD, ST_RELEASE} alc_state_t;
  typedef logic [7:0] atten_t;
  typedef logic [15:0] word_t;
endpackage

// ==== hdl/sample_stream_if.sv ====
// Valid/ready sample stream between the limiter core and its output buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface sample_stream_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== hdl/two_entry_buffer.sv ====
// Small valid/ready buffer that absorbs receiver stalls without losing a word.
// Assumes one clock, synchronous active-high reset and a common clock enable.
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  sample_stream_if.snk push,
  sample_stream_if.src pop
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic do_push, do_pop;

  assign push.ready = (count != FULL);
  assign pop.valid = (count != '0);
  assign pop.data = mem[rd_ptr];
  assign do_push = push.valid && push.ready && clk_en_in;
  assign do_pop = pop.valid && pop.ready && clk_en_in;

  // Pointers wrap at depth, so depth need not be a power of two
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (do_push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
    end
    if (do_pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
    end
    if (do_push && !do_pop) begin
      next_count = (PW + 1)'(count + 1'b1);
    end else if (do_pop && !do_push) begin
      next_count = (PW + 1)'(count - 1'b1);
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_comb begin
        next_mem[i] = mem[i];
        if (do_push && (wr_ptr == PW'(i))) begin
          next_mem[i] = push.data;
        end
      end
      always_ff @(posedge core_clk_in) begin
        mem[i] <= next_mem[i];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/level_limiter.sv ====
// Battery aware level limiter: registers, attack/hold/release control, gain stage.
// Assumes the battery code comes from on-chip logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "alc_cfg.svh"
module level_limiter
  import alc_pkg::*;
#(
  parameter int DCY_BASE_CYC = (`ALC_DCY_BASE_NS + `ALC_CLK_PERIOD_NS - 1) / `ALC_CLK_PERIOD_NS,
  parameter int HLD_BASE_CYC = (`ALC_HLD_BASE_NS + `ALC_CLK_PERIOD_NS - 1) / `ALC_CLK_PERIOD_NS,
  parameter int GAIN_STEPS_PER_FIELD = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  input wire logic [4:0] battery_code_in,
  input wire logic [15:0] sample_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  output logic [15:0] sample_out,
  output logic sample_valid_out,
  input wire logic sample_ready_in,
  output logic [7:0] gain_atten_out,
  output logic limiting_active_out
);
  localparam int ATK_BASE_CYC = (`ALC_ATK_BASE_NS + `ALC_CLK_PERIOD_NS - 1) / `ALC_CLK_PERIOD_NS;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  // ******************************
  // Register file
  // ******************************
  word_t gain_limits, step_timing, mode_battery, extra;
  word_t next_gain_limits, next_step_timing, next_mode_battery, next_extra;
  word_t next_rdata;
  alc_state_t state, next_state;
  atten_t atten, next_atten, applied, next_applied;

  always_comb begin
    next_gain_limits = gain_limits;
    next_step_timing = step_timing;
    next_mode_battery = mode_battery;
    next_extra = extra;
    if (reg_write_in) begin
      case (reg_addr_in)
        `ALC_OFS_GAIN_LIMITS: next_gain_limits = reg_wdata_in;
        `ALC_OFS_STEP_TIMING: next_step_timing = reg_wdata_in;
        `ALC_OFS_MODE_BATTERY: next_mode_battery = reg_wdata_in;
        `ALC_OFS_EXTRA: next_extra = reg_wdata_in;
        default: next_gain_limits = gain_limits;
      endcase
    end
    next_rdata = reg_rdata_out;
    if (reg_read_in) begin
      case (reg_addr_in)
        `ALC_OFS_GAIN_LIMITS: next_rdata = gain_limits;
        `ALC_OFS_STEP_TIMING: next_rdata = step_timing;
        `ALC_OFS_MODE_BATTERY: next_rdata = mode_battery;
        `ALC_OFS_EXTRA: next_rdata = extra;
        `ALC_OFS_STATUS: next_rdata = {5'h00, state, atten};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      gain_limits <= `ALC_RST_GAIN_LIMITS;
      step_timing <= `ALC_RST_STEP_TIMING;
      mode_battery <= `ALC_RST_MODE_BATTERY;
      extra <= `ALC_RST_EXTRA;
      reg_rdata_out <= 16'h0000;
    end else if (clk_en_in) begin
      gain_limits <= next_gain_limits;
      step_timing <= next_step_timing;
      mode_battery <= next_mode_battery;
      extra <= next_extra;
      reg_rdata_out <= next_rdata;
    end
  end

  // ******************************
  // Field decode and engagement
  // ******************************
  logic enable, en_prev, en_rise, below, engaged;
  logic [2:0] mode;
  logic [4:0] threshold;
  atten_t atten_min, atten_max;

  assign enable = mode_battery[`LEVEL_CONTROL_ENABLE_BIT];
  assign mode = mode_battery[`ALC_MODE_HI:`ALC_MODE_LO];
  assign threshold = mode_battery[`ALC_THR_HI:`ALC_THR_LO];
  assign en_rise = enable && !en_prev;
  // Higher code means lower voltage, so a plain code compare suffices
  assign below = (battery_code_in > threshold);

  // Attenuation counts 0.1875 dB steps; each gain field code spans a fixed step count
  assign atten_min = 8'((`ALC_GAIN_FIELD_TOP - gain_limits[`ALC_MAXG_HI:`ALC_MAXG_LO])
                        * GAIN_STEPS_PER_FIELD);
  assign atten_max = 8'((`ALC_GAIN_FIELD_TOP - gain_limits[`ALC_MING_HI:`ALC_MING_LO])
                        * GAIN_STEPS_PER_FIELD);

  always_comb begin
    case (mode)
      `ALC_MODE_NORMAL: engaged = 1'b1;
      `ALC_MODE_LOWBAT: engaged = below;
      `ALC_MODE_RATIO: engaged = 1'b1;
      default: engaged = 1'b0;
    endcase
  end

  // ******************************
  // Target level and ratio tracking
  // ******************************
  word_t base_target, ratio_target, next_ratio_target, target, hold_level, reduction;
  logic [7:0] ratio_mul;
  logic [4:0] battery_prev;
  logic recharging, next_recharging, freeze;

  assign base_target = {1'b0, step_timing[`ALC_LVL_HI:`ALC_LVL_LO], 12'hfff};
  assign ratio_mul = 8'(({1'b0, mode_battery[`ALC_RATIO_HI:`ALC_RATIO_LO]} + 3'h1)
                        * (battery_code_in - threshold));
  assign reduction = {ratio_mul, 8'h00};
  assign target = (mode == `ALC_MODE_RATIO && below) ? ratio_target : base_target;
  // About 1.47 dB under target, close enough for shift-only arithmetic
  assign hold_level = 16'(target - (target >> 3) - (target >> 5));
  assign freeze = (mode == `ALC_MODE_RATIO) && below && recharging;

  always_comb begin
    next_ratio_target = ratio_target;
    // A reduction past zero keeps the last positive target
    if (!below || reduction < base_target) begin
      next_ratio_target = below ? 16'(base_target - reduction) : base_target;
    end
    next_recharging = below && (recharging || (battery_code_in < battery_prev));
  end

  // ******************************
  // Peak detection and gain stage
  // ******************************
  sample_stream_if #(.WIDTH(16)) push_if ();
  sample_stream_if #(.WIDTH(16)) pop_if ();
  logic signed [25:0] product;
  logic [8:0] mant;
  word_t gained, mag, peak, next_peak, peak_now;
  logic fire, last_neg, zc_event, step;

  assign fire = sample_valid_in && push_if.ready;
  assign mant = 9'h100 - {2'h0, applied[4:0], 2'h0};
  assign product = $signed(sample_in) * $signed({1'b0, mant});
  assign gained = 16'(product >>> (5'd8 + {2'h0, applied[7:5]}));
  // Select set: true negation; clear: one's complement rectifier
  assign mag = !gained[15] ? gained :
               (gain_limits[`ALC_PKSEL_BIT] ? 16'(-gained) : ~gained);
  assign peak_now = (fire && mag > peak) ? mag : peak;
  assign zc_event = fire && ((sample_in[15] != last_neg) || sample_in == 16'h0000);

  always_comb begin
    next_peak = step ? 16'h0000 : peak_now;
    next_applied = applied;
    if (!gain_limits[`ZERO_CROSS_UPDATE_BIT] || zc_event) begin
      next_applied = atten;
    end
  end

  // ******************************
  // Step timer
  // ******************************
  logic [31:0] interval, tcount, next_tcount;

  always_comb begin
    case (state)
      ST_ATTACK: interval = 32'(ATK_BASE_CYC) << step_timing[`ALC_ATK_HI:`ALC_ATK_LO];
      ST_HOLD: interval = 32'(HLD_BASE_CYC) << step_timing[`ALC_HLD_HI:`ALC_HLD_LO];
      ST_RELEASE: interval = 32'(DCY_BASE_CYC) << step_timing[`ALC_DCY_HI:`ALC_DCY_LO];
      default: interval = 32'h0000_0001;
    endcase
    step = (state == ST_ATTACK || state == ST_HOLD || state == ST_RELEASE)
           && (tcount >= 32'(interval - 1));
    next_tcount = (step || next_state != state || freeze) ? 32'h0 : 32'(tcount + 1);
  end

  // ******************************
  // Attack, hold, release control
  // ******************************
  always_comb begin
    next_state = state;
    next_atten = atten;
    if (!enable || !engaged) begin
      next_state = ST_IDLE;
      next_atten = atten_min;
    end else if (en_rise || state == ST_IDLE) begin
      next_state = ST_MONITOR;
      next_atten = atten_min;
    end else if (!freeze) begin
      case (state)
        ST_MONITOR: begin
          if (peak_now > target) next_state = ST_ATTACK;
        end
        ST_ATTACK: begin
          if (step) begin
            if (peak_now > target) begin
              if (atten < atten_max) next_atten = 8'(atten + 1'b1);
            end else if (peak_now < hold_level) begin
              next_state = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (step) next_state = ST_RELEASE;
        end
        ST_RELEASE: begin
          if (step) begin
            if (peak_now > target) next_state = ST_ATTACK;
            else if (atten <= atten_min) next_state = ST_MONITOR;
            else next_atten = 8'(atten - 1'b1);
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      atten <= 8'h00;
      applied <= 8'h00;
      en_prev <= 1'b0;
      peak <= 16'h0000;
      tcount <= 32'h0;
      ratio_target <= 16'h0000;
      recharging <= 1'b0;
      battery_prev <= 5'h00;
      last_neg <= 1'b0;
    end else if (clk_en_in) begin
      state <= next_state;
      atten <= next_atten;
      applied <= next_applied;
      en_prev <= enable;
      peak <= next_peak;
      tcount <= next_tcount;
      ratio_target <= next_ratio_target;
      recharging <= next_recharging;
      battery_prev <= battery_code_in;
      last_neg <= fire ? sample_in[15] : last_neg;
    end
  end

  // ******************************
  // Output buffer and ports
  // ******************************
  assign push_if.data = gained;
  assign push_if.valid = sample_valid_in;
  assign sample_ready_out = push_if.ready;
  assign sample_out = pop_if.data;
  assign sample_valid_out = pop_if.valid;
  assign pop_if.ready = sample_ready_in;
  assign gain_atten_out = applied;
  assign limiting_active_out = (state != ST_IDLE);

  two_entry_buffer #(.WIDTH(16), .DEPTH(2)) u_buffer (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  // ******************************
  // Checks
  // ******************************
  sequence s_attack_step;
    clk_en_in && state == ST_ATTACK && step && !freeze && enable && engaged && !en_rise;
  endsequence

  a_enable_max_gain: assert property (clk_en_in && en_rise && engaged
    |=> atten == $past(atten_min) && state == ST_MONITOR)
    else $error("enable did not load maximum gain");
  a_lowbat_idle: assert property (clk_en_in && mode == `ALC_MODE_LOWBAT && !below
    |=> state == ST_IDLE && !limiting_active_out)
    else $error("limiter active with battery above threshold");
  a_attack_step_down: assert property (s_attack_step ##0 (peak_now > target)
    ##0 (atten < atten_max) |=> atten == 8'($past(atten) + 1'b1))
    else $error("attack step did not lower gain");
  a_attack_floor: assert property (s_attack_step ##0 (atten >= atten_max)
    |=> atten == $past(atten))
    else $error("attack went below minimum gain");
  a_monitor_attack: assert property (clk_en_in && state == ST_MONITOR && enable
    && engaged && !en_rise && !freeze && peak_now > target |=> state == ST_ATTACK)
    else $error("peak over target did not start attack");
  a_hold_release: assert property (clk_en_in && state == ST_HOLD && step && enable
    && engaged && !freeze |=> state == ST_RELEASE ##0 tcount == 32'h0)
    else $error("hold end did not enter release");
  a_release_ceiling: assert property (clk_en_in && state == ST_RELEASE && step
    && enable && engaged && !freeze && atten <= atten_min |=> atten == $past(atten))
    else $error("release passed maximum gain");
  a_zc_gate: assert property (clk_en_in && gain_limits[`ZERO_CROSS_UPDATE_BIT] && !zc_event
    |=> applied == $past(applied))
    else $error("gain applied away from zero crossing");
  a_ratio_freeze: assert property (clk_en_in && freeze && enable && engaged && !en_rise
    |=> atten == $past(atten) && state == $past(state))
    else $error("gain moved while battery recharging");
endmodule
`default_nettype wire

// ==== test/host_model.sv ====
// Host and receiver model: register writes and reads, and a stalling sample sink.
// Assumes the limiter samples its requests on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic core_clk_in,
  input wire logic [15:0] reg_rdata_in,
  input wire logic stall_in,
  output logic [7:0] reg_addr_out,
  output logic [15:0] reg_wdata_out,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic sample_ready_out
);
  logic [1:0] phase = 2'h0;
  // ********
  // Register access
  // ********
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
  end
  // Requests change on the falling edge and stand across one rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_write_out = 1'b1;
    @(negedge core_clk_in);
    reg_write_out = 1'b0;
    reg_wdata_out = ~d;  // Released data must not keep looking valid
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_read_out = 1'b1;
    @(negedge core_clk_in);
    reg_read_out = 1'b0;
    d = reg_rdata_in;
  endtask
  // Enable word goes last so the limiter starts on a full setup
  task automatic setup(input logic [15:0] lim, tim, mode);
    wr(8'h2c, lim);
    wr(8'h2d, tim);
    wr(8'h2e, mode);
  endtask
  // ********
  // Receiver: stalls one cycle in four, or throughout while stall_in is high
  // ********
  always @(negedge core_clk_in) begin
    phase <= phase + 2'h1;
    sample_ready_out <= !stall_in && (phase != 2'h3);
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the level limiter with a host and receiver model.
// Assumes shortened release and hold bases so the run stays short.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import alc_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} reg_row_t;
  typedef struct {logic [2:0] m; logic [4:0] b; logic act;} mode_row_t;
  logic core_clk_in, reset_in, clk_en_in, stall, neg, took, chk_out, bound_on;
  logic reg_write, reg_read, sample_ready_out, sample_valid_out, sample_ready_in;
  logic limiting_active_out;
  logic [7:0] reg_addr, gain_atten_out;
  logic [15:0] reg_wdata, reg_rdata_out, sample_out, amp, rd_val;
  logic [4:0] battery;
  int failures, n_compared, cycles;
  reg_row_t rows[6] = '{'{8'h2c, 16'h68e2, 16'h68e2}, '{8'h2d, 16'h5353, 16'h5353},
    '{8'h2e, 16'h0260, 16'h0260}, '{8'h2f, 16'h0c20, 16'h0c20},
    '{8'h31, 16'h1234, 16'h0000}, '{8'h30, 16'hffff, 16'h0000}};
  mode_row_t modes[6] = '{'{3'h3, 5'h05, 1'b0}, '{3'h3, 5'h14, 1'b1}, '{3'h2, 5'h05, 1'b1},
    '{3'h4, 5'h05, 1'b1}, '{3'h0, 5'h14, 1'b0}, '{3'h1, 5'h14, 1'b0}};
  level_limiter #(.DCY_BASE_CYC(4), .HLD_BASE_CYC(8)) dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
    .reg_read_in(reg_read), .reg_rdata_out(reg_rdata_out), .battery_code_in(battery),
    .sample_in(neg ? -amp : amp), .sample_valid_in(1'b1), .sample_ready_out(sample_ready_out),
    .sample_out(sample_out), .sample_valid_out(sample_valid_out),
    .sample_ready_in(sample_ready_in), .gain_atten_out(gain_atten_out),
    .limiting_active_out(limiting_active_out));
  host_model host (.core_clk_in(core_clk_in), .reg_rdata_in(reg_rdata_out), .stall_in(stall),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_write_out(reg_write),
    .reg_read_out(reg_read), .sample_ready_out(sample_ready_in));
  // ********
  // Clock, checks and closing
  // ********
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  task automatic check(input logic [15:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_gain(input logic [7:0] t, input int limit);
    int n;
    n = 0;
    while (gain_atten_out !== t && n < limit) begin
      @(negedge core_clk_in);
      n++;
    end
    check({8'h00, gain_atten_out}, {8'h00, t}, "gain settle");
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  // Sign flips on every accepted word so zero crossings keep coming
  always @(posedge core_clk_in) took <= sample_ready_out && clk_en_in;
  always @(negedge core_clk_in) if (took) neg <= !neg;
  // Gain must stay inside 16..80 with max field 6 and min field 2
  always @(posedge core_clk_in) if (bound_on) begin
    check({15'h0, gain_atten_out >= 8'd16}, 16'h1, "gain above maximum");
    check({15'h0, gain_atten_out <= 8'd80}, 16'h1, "gain below minimum");
  end
  // At the floor, +/-7fff scaled by 192/1024
  always @(posedge core_clk_in) if (chk_out && sample_valid_out && sample_ready_in)
    check({15'h0, sample_out === 16'h17ff || sample_out === 16'he800}, 16'h1, "sample");
  // ********
  // Main sequence
  // ********
  initial begin
    reset_in = 1'b1;
    clk_en_in = 1'b1;
    battery = 5'h05;
    amp = 16'h7fff;
    {neg, took, stall, chk_out, bound_on} = 5'h00;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (4) @(negedge core_clk_in);
    reset_in = 1'b0;
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, rd_val);
      check(rd_val, rows[i].e, "register row");
    end
    clk_en_in = 1'b0;
    host.wr(8'h2f, 16'h1111);
    clk_en_in = 1'b1;
    host.rd(8'h2f, rd_val);
    check(rd_val, 16'h0c20, "write with clock enable low");
    // Second reset in mid-run
    reset_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    check({8'h00, gain_atten_out}, 16'h0000, "gain in reset");
    check({15'h0, limiting_active_out}, 16'h0000, "active in reset");
    check({15'h0, sample_valid_out}, 16'h0000, "valid in reset");
    reset_in = 1'b0;
    host.rd(8'h2c, rd_val);
    check(rd_val, 16'h0000, "reset value");
    host.rd(8'h2f, rd_val);
    check(rd_val, 16'h0020, "reset value");
    // Low-battery mode, threshold 10, target 0fff, fastest timers
    host.setup(16'h48c4, 16'h0000, 16'hb140);
    bound_on = 1'b1;
    repeat (2) @(negedge core_clk_in);
    check({8'h00, gain_atten_out}, 16'h0010, "gain on enable");
    repeat (8) @(negedge core_clk_in);
    check({15'h0, limiting_active_out}, 16'h0000, "active above threshold");
    battery = 5'h14;
    repeat (3) @(negedge core_clk_in);
    check({15'h0, limiting_active_out}, 16'h0001, "active below threshold");
    wait_gain(8'd80, 4000);
    repeat (30) @(negedge core_clk_in);
    chk_out = 1'b1;
    stall = 1'b1;
    repeat (6) @(negedge core_clk_in);
    check({15'h0, sample_ready_out}, 16'h0000, "buffer full");
    stall = 1'b0;
    repeat (20) @(negedge core_clk_in);
    chk_out = 1'b0;
    host.rd(8'h30, rd_val);
    check(rd_val, 16'h0250, "status at floor");
    // Quiet signal: hold, then release back to the ceiling
    amp = 16'h0100;
    wait_gain(8'd16, 3000);
    // Release leaves for monitor only on the step after reaching the ceiling
    repeat (8) @(negedge core_clk_in);
    host.rd(8'h30, rd_val);
    check(rd_val, 16'h0110, "status after release");
    battery = 5'h05;
    repeat (3) @(negedge core_clk_in);
    check({15'h0, limiting_active_out}, 16'h0000, "idle on recharge");
    foreach (modes[i]) begin
      battery = modes[i].b;
      host.wr(8'h2e, {1'b0, modes[i].m, 12'h140});
      host.wr(8'h2e, {1'b1, modes[i].m, 12'h140});
      repeat (3) @(negedge core_clk_in);
      check({15'h0, limiting_active_out}, {15'h0, modes[i].act}, "mode");
    end
    // Ratio mode, ratio 3, threshold 10: code 12 pulls the target to 07ff
    battery = 5'h05;
    amp = 16'h0f00;
    host.wr(8'h2e, 16'hcd40);
    battery = 5'h0c;
    repeat (100) @(negedge core_clk_in);
    check({15'h0, gain_atten_out > 8'd16}, 16'h1, "ratio target attack");
    // Code falling while still below threshold means recharging: gain must freeze
    battery = 5'h0b;
    repeat (4) @(negedge core_clk_in);
    rd_val = {8'h00, gain_atten_out};
    repeat (200) @(negedge core_clk_in);
    check({8'h00, gain_atten_out}, rd_val, "gain held while recharging");
    summarize();
  end
endmodule
`default_nettype wire
